// ===== bench/grl_glyph_ram_loader_tb.sv
// Bench for the glyph loader: pointer loads, column writes, scan limit, blink rate.
// Assumes shortened count parameters; reads are matched through a queue of notes.
`timescale 1ns/100ps
`default_nettype none
module grl_glyph_ram_loader_tb;
    localparam int PT = 4, FH = 5, SH = 10;
    logic core_clk, rst_n, wrEn, rdEn, blinkSlow, digitCountBit, scanPhase, blinkPhase;
    logic [7:0] regAddr, wrData, rdData, q[$];
    logic [6:0] glyphRdIdx, glyphRdCol, glyphPtr;
    logic [1:0] digitEnable;
    logic       pend = 1'b0;
    logic [7:0] col[5] = '{8'h42, 8'h61, 8'h51, 8'h49, 8'h46};
    logic [31:0] seed = 32'h2fd2327a;
    int fails, compares, cyc, n;
    grl_glyph_ram_loader #(.PHASE_TICKS(PT), .FAST_HALF(FH), .SLOW_HALF(SH)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .wrEn(wrEn), .rdEn(rdEn), .regAddr(regAddr),
        .wrData(wrData), .blinkSlow(blinkSlow), .glyphRdIdx(glyphRdIdx), .rdData(rdData),
        .glyphRdCol(glyphRdCol), .glyphPtr(glyphPtr), .digitCountBit(digitCountBit),
        .digitEnable(digitEnable), .scanPhase(scanPhase), .blinkPhase(blinkPhase));
    grl_host_model host (.core_clk(core_clk), .wrEn(wrEn), .rdEn(rdEn),
        .regAddr(regAddr), .wrData(wrData));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        host.acc(1'b0, a, 8'h00);
    endtask : rd
    // Upper bits are random so only the low bit may steer the scan.
    task automatic scan(input logic v);
        logic [7:0] r;
        logic b;
        r = 8'($random(seed));
        r[0] = v;
        host.acc(1'b1, 8'h03, r);
        rd(8'h03, r);
        host.idle();
        chk(8'(digitCountBit), 8'(v));
        n = 0;
        repeat (8 * PT) begin
            b = scanPhase;
            @(posedge core_clk);
            #1;
            n += int'(scanPhase !== b);
            chk(8'(digitEnable), v ? {6'h00, scanPhase, !scanPhase} : 8'h01);
        end
        chk(8'(n), v ? 8'h08 : 8'h00);
    endtask : scan
    task automatic halfp(input logic s, input int e);
        logic b;
        blinkSlow = s;
        repeat (2) @(blinkPhase);
        b = blinkPhase;
        for (n = 1; n < 40; n++) begin
            @(posedge core_clk);
            #1;
            if (blinkPhase !== b) break;
        end
        chk(8'(n), 8'(e));
    endtask : halfp
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // A hang counts as a mismatch and ends the run.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            give_verdict();
        end
    end
    // A read result lands one cycle after its strobe; match it to the oldest note.
    always @(negedge core_clk) begin
        if (pend) chk(rdData, q.pop_front());
        pend = rdEn;
    end
    initial begin
        rst_n = 1'b0;
        blinkSlow = 1'b0;
        glyphRdIdx = 7'h0a;
        repeat (10) @(posedge core_clk);
        chk(8'(glyphPtr), 8'h00);
        chk(8'(digitEnable), 8'h01);
        #1;
        rst_n = 1'b1;
        host.acc(1'b1, 8'h05, 8'h8a);
        foreach (col[k]) host.acc(1'b1, 8'h05, col[k]);
        host.acc(1'b1, 8'h04, 8'h80);
        rd(8'h05, 8'h8f);
        rd(8'h04, 8'h00);
        host.idle();
        chk(8'(glyphPtr), 8'h0f);
        foreach (col[k]) begin
            glyphRdIdx = 7'(10 + k);
            repeat (2) @(posedge core_clk);
            #1;
            chk(8'(glyphRdCol), col[k]);
        end
        glyphRdIdx = 7'h7f;
        repeat (2) @(posedge core_clk);
        #1;
        chk(8'(glyphRdCol), 8'h00);
        $display("glyph load test done");
        scan(1'b0);
        scan(1'b1);
        scan(1'b0);
        $display("scan limit test done");
        // A second reset in mid-run must clear the pointer, the scan bit and the store.
        rst_n = 1'b0;
        glyphRdIdx = 7'h0a;
        @(posedge core_clk);
        #1;
        chk(8'(glyphPtr), 8'h00);
        chk(8'(digitCountBit), 8'h00);
        chk(8'(digitEnable), 8'h01);
        rst_n = 1'b1;
        host.idle();
        chk(8'(glyphRdCol), 8'h00);
        $display("mid-run reset test done");
        halfp(1'b0, FH);
        halfp(1'b1, SH);
        $display("blink rate test done");
        give_verdict();
    end
endmodule : grl_glyph_ram_loader_tb
`default_nettype wire

// ===== bench/grl_host_model.sv
// Host model: drives the register strobes, one access per cycle at most.
// Assumes the bench calls acc and idle from one process only.
`timescale 1ns/100ps
`default_nettype none
module grl_host_model (
    input  wire logic       core_clk, // Oscillator clock.
    output var  logic       wrEn,     // Write strobe.
    output var  logic       rdEn,     // Read strobe.
    output var  logic [7:0] regAddr,  // Register address.
    output var  logic [7:0] wrData    // Write data.
);
    initial begin
        {wrEn, rdEn, regAddr, wrData} = '0;
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        {wrEn, rdEn, regAddr, wrData} = {w, !w, a, d};
    endtask : acc
    // Released lines flip so that a stale value can never pass for a fresh one.
    task automatic idle();
        @(posedge core_clk);
        #1;
        {wrEn, rdEn, regAddr, wrData} = {2'b00, ~regAddr, ~wrData};
    endtask : idle
endmodule : grl_host_model
`default_nettype wire

// ===== rtl/grl_blink_div.sv
// Blink divider: toggles a phase output at 1 Hz or 0.5 Hz.
// Assumes core_clk is the 4 MHz oscillator domain clock.
`timescale 1ns/100ps
`default_nettype none
module grl_blink_div #(
    parameter int FAST_HALF = grl_pkg::BLINK_FAST_HALF, // Half period at 1 Hz.
    parameter int SLOW_HALF = grl_pkg::BLINK_SLOW_HALF  // Half period at 0.5 Hz.
) (
    input  wire logic core_clk,  // Oscillator clock.
    input  wire logic rst_n,     // Asynchronous reset, active low.
    input  wire logic slowRate,  // High selects 0.5 Hz.
    output var  logic blinkPhase // Blink phase level.
);
    logic [31:0] count;
    wire  [31:0] halfLimit = slowRate ? 32'(SLOW_HALF - 1) : 32'(FAST_HALF - 1);
    wire         wrapNow   = (count >= halfLimit);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count      <= 32'h0;
            blinkPhase <= 1'b1;
        end else if (wrapNow) begin
            count      <= 32'h0;
            blinkPhase <= ~blinkPhase;
        end else begin
            count <= count + 32'h1;
        end
    end
endmodule : grl_blink_div
`default_nettype wire

// ===== rtl/grl_glyph_ram_loader.sv
// Register bank for glyph RAM loading, scan limit and digit multiplexing.
// Holds the auto-incrementing glyph pointer, the column store, the scan-limit register,
// the paired digit multiplexer and the blink divider instance.
// Assumes wrEn/rdEn are one-cycle strobes from the serial front end.
// Assumes the font engine reads columns through glyphRdIdx in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module grl_glyph_ram_loader #(
    parameter int DEPTH       = grl_pkg::GLYPH_DEPTH,       // Glyph RAM locations.
    parameter int PHASE_TICKS = grl_pkg::SCAN_PHASE_CYCLES, // Cycles per scan phase.
    parameter int FAST_HALF   = grl_pkg::BLINK_FAST_HALF,   // 1 Hz half period.
    parameter int SLOW_HALF   = grl_pkg::BLINK_SLOW_HALF    // 0.5 Hz half period.
) (
    input  wire logic       core_clk,   // Oscillator clock, 4 MHz.
    input  wire logic       rst_n,      // Asynchronous reset, active low.
    input  wire logic       wrEn,       // Register write strobe.
    input  wire logic       rdEn,       // Register read strobe.
    input  wire logic [7:0] regAddr,    // Register address.
    input  wire logic [7:0] wrData,     // Write data.
    input  wire logic       blinkSlow,  // High selects 0.5 Hz blink.
    input  wire logic [6:0] glyphRdIdx, // Font engine read index.
    output var  logic [7:0] rdData,     // Registered read data.
    output var  logic [6:0] glyphRdCol, // Registered column at glyphRdIdx.
    output var  logic [6:0] glyphPtr,   // Current glyph pointer.
    output var  logic       digitCountBit, // Scan-limit bit.
    output var  logic [1:0] digitEnable, // Active digit pair, one-hot per pair.
    output var  logic       scanPhase,  // Zero for digits 0/1, one for 2/3.
    output var  logic       blinkPhase  // Blink phase level.
);
    // Storage and state.
    logic [6:0] glyphMem [DEPTH];
    logic [7:0] scanLimitSelect;
    logic [31:0] phaseCount;

    // The pointer is kept as seven bits; the flag bit of the port byte only marks a load
    // and is never stored, so a readback shows it set again.
    // Locations at or above DEPTH do not exist: a data write there still moves the
    // pointer but stores nothing, rather than folding the write onto a lower location.
    // A limitation to keep in mind: the pointer wraps within seven bits, so a burst that
    // runs past the top address carries on from location zero.
    // The whole scan-limit byte is kept so that the host reads back what it wrote, even
    // though only the lowest bit steers the multiplexer.
    // Every register has an asynchronous reset, so the glyph store starts blank and the
    // multiplexer starts on the low digit pair.

    // Register decode.
    wire glyphHit  = wrEn && (regAddr == grl_pkg::GLYPH_RAM_PORT_ADDR);
    wire scanHit   = wrEn && (regAddr == grl_pkg::SCAN_LIMIT_SELECT_ADDR);
    wire ptrLoad   = glyphHit && wrData[grl_pkg::POINTER_FLAG_POS];
    wire dataWrite = glyphHit && !wrData[grl_pkg::POINTER_FLAG_POS];
    wire ptrValid  = (32'(glyphPtr) < 32'(DEPTH));
    wire [6:0] next_glyphPtr = ptrLoad ? wrData[6:0] :
                               dataWrite ? glyphPtr + 7'h1 : glyphPtr;
    wire fourDigits = scanLimitSelect[grl_pkg::DIGIT_COUNT_BIT_POS];
    wire phaseWrap  = (phaseCount >= 32'(PHASE_TICKS - 1));
    wire [7:0] next_rdData =
        (regAddr == grl_pkg::SCAN_LIMIT_SELECT_ADDR) ? scanLimitSelect :
        (regAddr == grl_pkg::GLYPH_RAM_PORT_ADDR)    ? {1'b1, glyphPtr} : 8'h00;

    // Font engine lookup; an index past the last location reads as blank columns.
    wire       rdIdxValid      = (32'(glyphRdIdx) < 32'(DEPTH));
    wire [6:0] next_glyphRdCol = rdIdxValid ? glyphMem[glyphRdIdx] : 7'h00;

    // four digits alternate
    // The low pair is forced at once rather than at the end of the phase, so a host
    // that narrows the scan never sees the upper pair lit for the rest of a phase.
    // Widening the scan waits for the next phase boundary, which keeps phases whole.
    wire next_scanPhase = !fourDigits ? 1'b0 :
                          phaseWrap   ? ~scanPhase : scanPhase;

    // pointer load and advance after data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            glyphPtr <= grl_pkg::POINTER_RESET;
        end else begin
            glyphPtr <= next_glyphPtr;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_mem
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    glyphMem[gi] <= 7'h00;
                end else if (dataWrite && ptrValid && (32'(glyphPtr) == gi)) begin
                    glyphMem[gi] <= wrData[6:0];
                end
            end
        end
    endgenerate

    // Scan-limit register keeps all bits for readback; only bit zero steers.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scanLimitSelect <= grl_pkg::SCAN_LIMIT_RESET;
        end else if (scanHit) begin
            scanLimitSelect <= wrData;
        end
    end

    // Read data and font engine column are registered.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData     <= 8'h00;
            glyphRdCol <= 7'h00;
        end else begin
            if (rdEn) begin
                rdData <= next_rdData;
            end
            glyphRdCol <= next_glyphRdCol;
        end
    end

    // paired scan phases
    // The counter runs in both modes, so a phase lasts the same time whatever the limit,
    // and a later switch to four digits moves to the upper pair at the next wrap of the running count.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phaseCount <= 32'h0;
            scanPhase  <= 1'b0;
        end else begin
            phaseCount <= phaseWrap ? 32'h0 : phaseCount + 32'h1;
            scanPhase  <= next_scanPhase;
        end
    end

    assign digitCountBit = fourDigits;
    assign digitEnable   = scanPhase ? 2'b10 : 2'b01;

    // Blink divider; it runs from reset on its own and does not depend on the scan limit.
    // The rate select is passed straight through, so a change takes effect mid-period.
    grl_blink_div #(
        .FAST_HALF (FAST_HALF),
        .SLOW_HALF (SLOW_HALF)
    ) u_blink (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .slowRate   (blinkSlow),
        .blinkPhase (blinkPhase)
    );

    // Pointer handling: loads, advances, and writes elsewhere that must leave it alone.
    // pointer load check
    a_ptr_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        ptrLoad |=> glyphPtr == $past(wrData[6:0])) else $error("pointer not loaded");
    a_ptr_advance: assert property (@(posedge core_clk) disable iff (!rst_n)
        dataWrite |=> glyphPtr == $past(glyphPtr) + 7'h1) else $error("pointer not advanced");
    a_ptr_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !glyphHit |=> $stable(glyphPtr)) else $error("pointer moved without write");
    a_other_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrEn && !glyphHit && !scanHit) |=> $stable(glyphPtr) && $stable(scanLimitSelect))
        else $error("write to another address took effect");

    // Column storage, the pointer-load path and the font engine lookup.
    // column store check
    a_col_store: assert property (@(posedge core_clk) disable iff (!rst_n)
        (dataWrite && ptrValid) |=> glyphMem[$past(glyphPtr)] == $past(wrData[6:0]))
        else $error("column not stored");
    a_data_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrEn && regAddr == grl_pkg::GLYPH_RAM_PORT_ADDR && wrData[7] && ptrValid)
        |=> glyphMem[$past(glyphPtr)] == $past(glyphMem[glyphPtr]))
        else $error("pointer write stored as data");
    a_col_lookup: assert property (@(posedge core_clk) disable iff (!rst_n)
        rdIdxValid |=> glyphRdCol == $past(glyphMem[glyphRdIdx]))
        else $error("font engine column wrong");
    a_col_blank: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rdIdxValid |=> glyphRdCol == 7'h00) else $error("missing location not blank");

    // Readback: the scan register keeps every bit and the port shows the pointer.
    // scan register readback
    a_scan_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rdEn && regAddr == grl_pkg::SCAN_LIMIT_SELECT_ADDR)
        |=> rdData == $past(scanLimitSelect)) else $error("scan register readback wrong");
    a_port_readback: assert property (@(posedge core_clk) disable iff (!rst_n)
        (rdEn && regAddr == grl_pkg::GLYPH_RAM_PORT_ADDR)
        |=> rdData == {1'b1, $past(glyphPtr)}) else $error("pointer readback wrong");
    a_read_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rdEn |=> $stable(rdData)) else $error("read data moved without a read");

    // Scan multiplexer: pair order, phase length and the single steering bit.
    // low pair only
    a_two_digit: assert property (@(posedge core_clk) disable iff (!rst_n)
        !fourDigits |=> !scanPhase) else $error("upper pair driven in two-digit mode");
    a_four_digit: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fourDigits && phaseWrap) |=> scanPhase != $past(scanPhase))
        else $error("phase did not alternate");
    a_pair_onehot: assert property (@(posedge core_clk) disable iff (!rst_n)
        $onehot(digitEnable) && digitEnable[1] == scanPhase) else $error("pair select wrong");
    a_pair_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fourDigits && !phaseWrap) |=> $stable(digitEnable))
        else $error("pair changed within a phase");
    a_phase_range: assert property (@(posedge core_clk) disable iff (!rst_n)
        phaseCount < 32'(PHASE_TICKS)) else $error("phase counter out of range");
    a_bit_decides: assert property (@(posedge core_clk) disable iff (!rst_n)
        scanHit |=> digitCountBit == $past(wrData[0])) else $error("scan bit mismatch");

    // Cover the load, a data burst, both scan modes and a pointer readback.
    c_ptr_load:  cover property (@(posedge core_clk) ptrLoad);
    c_data_pair: cover property (@(posedge core_clk) dataWrite ##1 dataWrite);
    c_four_mode: cover property (@(posedge core_clk) fourDigits && phaseWrap);
    c_two_mode:  cover property (@(posedge core_clk) !fourDigits && phaseWrap);
    c_port_read: cover property (@(posedge core_clk)
        rdEn && regAddr == grl_pkg::GLYPH_RAM_PORT_ADDR);
endmodule : grl_glyph_ram_loader
`default_nettype wire

// ===== shared/grl_pkg.sv
// Constants shared by the glyph RAM loader and scan-limit register bank.
// Assumes a decoded register write strobe arriving from the serial front end.
//
// Overview of operation
// - A write with a pointer value such as 0x8A to register 0x05 loads the glyph pointer.
// - Each later data write to register 0x05 stores a 7-bit column (pointer below 120) and advances the pointer.
// - Five data writes from 0x8A fill 0x0A to 0x0E and leave the pointer at 0x0F (read back as 0x8F).
// - Scan-limit bit clear drives only digits 0 and 1, upper bits ignored.
// - Scan-limit bit set drives all four digits, upper bits ignored.
// - With a 4 MHz oscillator the blink divider offers 0.5 Hz or 1 Hz.
// - Digits 0 and 1 share one scan phase, digits 2 and 3 the next.
// - A single bit decides the scan limit.
package grl_pkg;
    localparam logic [7:0]  SCAN_LIMIT_SELECT_ADDR = 8'h03;
    localparam logic [7:0]  GLYPH_RAM_PORT_ADDR    = 8'h05;
    localparam int          DIGIT_COUNT_BIT_POS    = 0;
    localparam int          POINTER_FLAG_POS       = 7;
    localparam logic [6:0]  POINTER_RESET          = 7'h00;
    localparam logic [7:0]  SCAN_LIMIT_RESET       = 8'h00;
    localparam int          GLYPH_DEPTH            = 120;
    localparam int          OSC_HZ                 = 4000000;
    localparam int          SCAN_PHASE_CYCLES      = 2000;
    // Half periods of the two blink rates, in oscillator cycles.
    localparam int          BLINK_FAST_HALF        = OSC_HZ / 2;
    localparam int          BLINK_SLOW_HALF        = OSC_HZ;
endpackage : grl_pkg
